/* File: logic/swc_stop_control.sv */
`include "swc_defs.svh"

module swc_stop_control #(
    parameter int CLK_KHZ = `SWC_CLK_KHZ,
    parameter int DELAY_US = `SWC_DELAY_US,
    parameter int DELAY_CYCLES = (CLK_KHZ * DELAY_US + 999) / 1000,
    parameter int OSC_CYCLES = `SWC_OSC_START,
    parameter int HOLD_CYCLES = `SWC_FAST_HOLD
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    input wire logic por_in,
    input wire logic ext_reset_in,
    input wire logic watchdog_timeout_in,
    input wire logic stop_exec_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [3:0] port3_in,
    input wire logic [3:1] port3_analog_in,
    input wire logic [7:0] port2_pin_in,
    input wire logic [7:0] port2_drive_in,
    input wire logic [7:0] port2_out_en_in,
    output logic [7:0] reg_rdata_out,
    output logic core_clk_en_out,
    output logic osc_en_out,
    output logic core_reset_out,
    output logic full_reset_out,
    output logic [15:0] restart_addr_out,
    output logic div16_en_out,
    output logic bypass_div2_out,
    output logic sys_tick_out,
    output logic irq_out
);
    localparam int CNT_W = $clog2(DELAY_CYCLES + 2);

    // One counter serves every phase, so it is sized by the longest one
    if (DELAY_CYCLES < 1) begin : g_bad_delay
        $error("swc_stop_control: delay count must be at least one");
    end
    if (OSC_CYCLES < 1 || OSC_CYCLES > DELAY_CYCLES) begin : g_bad_osc
        $error("swc_stop_control: start-up count out of range");
    end
    if (HOLD_CYCLES < 1 || HOLD_CYCLES > DELAY_CYCLES) begin : g_bad_hold
        $error("swc_stop_control: hold count out of range");
    end

    swc_pkg::swc_state_t state_q;
    logic [6:0] ctrl_q;
    logic warm_q;
    logic [1:0] extra_q;
    logic [`SWC_IRQ_W-1:0] irq_stat_q;
    logic [`SWC_IRQ_W-1:0] irq_mask_q;
    logic [CNT_W-1:0] cnt_q;
    logic [4:0] div_q;
    logic [7:0] rdata_q;
    logic wake_now;
    logic wake_hit;
    logic hard_reset;
    logic ev_stop;
    logic ev_wake;
    logic ev_ready;
    logic [`SWC_IRQ_W-1:0] ev_vec;
    logic tick_raw;

    function automatic logic is_addr(input logic [3:0] a, input logic [3:0] b);
        return a == b;
    endfunction : is_addr

    // Status codes stay fixed whatever encoding the state enum gets
    function automatic logic [2:0] state_code(input swc_pkg::swc_state_t s);
        logic [2:0] code;
        code = `SWC_STAT_RUN;
        case (s)
            swc_pkg::SWC_STOPPED: code = `SWC_STAT_STOPPED;
            swc_pkg::SWC_OSC_START: code = `SWC_STAT_OSC;
            swc_pkg::SWC_DELAY: code = `SWC_STAT_DELAY;
            swc_pkg::SWC_RELEASE: code = `SWC_STAT_RELEASE;
            default: code = `SWC_STAT_RUN;
        endcase
        return code;
    endfunction : state_code

    swc_wake_detect u_wake (
        .src_sel_in(ctrl_q[`SWC_SRC_HI:`SWC_SRC_LO]),
        .extra_sel_in(extra_q),
        .level_high_in(ctrl_q[`SWC_BIT_LEVEL]),
        .port3_in(port3_in),
        .port3_analog_in(port3_analog_in),
        .port2_pin_in(port2_pin_in),
        .port2_drive_in(port2_drive_in),
        .port2_out_en_in(port2_out_en_in),
        .wake_out(wake_now)
    );

    assign hard_reset = por_in | ext_reset_in | watchdog_timeout_in;
    assign wake_hit = (state_q == swc_pkg::SWC_STOPPED) & wake_now;
    assign ev_stop = (state_q == swc_pkg::SWC_RUN) & stop_exec_in
                     & ~hard_reset;
    assign ev_wake = wake_hit | ((state_q == swc_pkg::SWC_STOPPED)
                                 & hard_reset);
    assign ev_ready = state_q == swc_pkg::SWC_RELEASE;

    // Stop sequence; the oscillator is modelled as needing a settle time
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= swc_pkg::SWC_RUN;
            cnt_q <= '0;
        end else if (clk_en_in) begin
            case (state_q)
                swc_pkg::SWC_RUN: begin
                    if (stop_exec_in && !hard_reset) begin
                        state_q <= swc_pkg::SWC_STOPPED;
                    end
                    cnt_q <= '0;
                end
                swc_pkg::SWC_STOPPED: begin
                    if (hard_reset) begin
                        state_q <= swc_pkg::SWC_OSC_START;
                        cnt_q <= '0;
                    end else if (wake_now) begin
                        // Fast wake demands a held source; the delay path
                        // accepts any single sampled level
                        if (ctrl_q[`SWC_BIT_DELAY] ||
                            cnt_q == CNT_W'(HOLD_CYCLES - 1)) begin
                            state_q <= swc_pkg::SWC_OSC_START;
                            cnt_q <= '0;
                        end else begin
                            cnt_q <= cnt_q + 1'b1;
                        end
                    end else begin
                        cnt_q <= '0;
                    end
                end
                swc_pkg::SWC_OSC_START: begin
                    if (cnt_q == CNT_W'(OSC_CYCLES - 1)) begin
                        cnt_q <= '0;
                        state_q <= ctrl_q[`SWC_BIT_DELAY]
                                   ? swc_pkg::SWC_DELAY
                                   : swc_pkg::SWC_RELEASE;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                swc_pkg::SWC_DELAY: begin
                    if (cnt_q == CNT_W'(DELAY_CYCLES - 1)) begin
                        cnt_q <= '0;
                        state_q <= swc_pkg::SWC_RELEASE;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                swc_pkg::SWC_RELEASE: begin
                    state_q <= swc_pkg::SWC_RUN;
                end
                default: state_q <= swc_pkg::SWC_RUN;
            endcase
        end
    end

    // Wake settings survive stop recovery; only reset or power-on clears
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_q <= `SWC_CTRL_RST;
            extra_q <= `SWC_EXTRA_RST;
        end else if (clk_en_in) begin
            if (por_in || ext_reset_in) begin
                ctrl_q <= `SWC_CTRL_RST;
                extra_q <= `SWC_EXTRA_RST;
            end else if (reg_write_in) begin
                if (is_addr(reg_addr_in, `SWC_ADDR_CTRL)) begin
                    ctrl_q <= reg_wdata_in[6:0];
                end else if (is_addr(reg_addr_in, `SWC_ADDR_EXTRA)) begin
                    extra_q <= reg_wdata_in[1:0];
                end
            end
        end
    end

    // Warm flag: set on stop entry, cleared only by power-on
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            warm_q <= 1'b0;
        end else if (clk_en_in) begin
            if (por_in) begin
                warm_q <= 1'b0;
            end else if (ev_stop && !hard_reset) begin
                warm_q <= 1'b1;
            end
        end
    end

    // Clock prescaler: divide-by-two unless bypassed, then by 16 if asked
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            div_q <= '0;
        end else if (clk_en_in && core_clk_en_out) begin
            div_q <= div_q + 1'b1;
        end
    end

    always_comb begin
        case ({ctrl_q[`SWC_BIT_DIV16], ctrl_q[`SWC_BIT_BYPASS2]})
            2'b00: tick_raw = div_q[0];
            2'b01: tick_raw = 1'b1;
            2'b10: tick_raw = &div_q[4:0];
            default: tick_raw = &div_q[3:0];
        endcase
    end

    assign sys_tick_out = tick_raw & core_clk_en_out;

    // Interrupt status: set wins over write-one clear
    assign ev_vec = {ev_ready, ev_wake, ev_stop};

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
        end else if (clk_en_in) begin
            if (reg_write_in &&
                is_addr(reg_addr_in, `SWC_ADDR_IRQ_STAT)) begin
                irq_stat_q <= (irq_stat_q & ~reg_wdata_in[`SWC_IRQ_W-1:0])
                              | ev_vec;
            end else begin
                irq_stat_q <= irq_stat_q | ev_vec;
            end
            if (reg_write_in &&
                is_addr(reg_addr_in, `SWC_ADDR_IRQ_MASK)) begin
                irq_mask_q <= reg_wdata_in[`SWC_IRQ_W-1:0];
            end
        end
    end

    // Read port; unmapped and write-only bits read zero
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_q <= '0;
        end else if (clk_en_in) begin
            rdata_q <= '0;
            if (reg_read_in) begin
                if (is_addr(reg_addr_in, `SWC_ADDR_CTRL)) begin
                    rdata_q <= {warm_q, 7'h00};
                end else if (is_addr(reg_addr_in, `SWC_ADDR_IRQ_STAT)) begin
                    rdata_q <= {5'h00, irq_stat_q};
                end else if (is_addr(reg_addr_in, `SWC_ADDR_IRQ_MASK)) begin
                    rdata_q <= {5'h00, irq_mask_q};
                end else if (is_addr(reg_addr_in, `SWC_ADDR_STATUS)) begin
                    rdata_q <= {5'h00, state_code(state_q)};
                end
            end
        end
    end

    assign reg_rdata_out = rdata_q;
    assign irq_out = |(irq_stat_q & irq_mask_q);
    assign core_clk_en_out = state_q == swc_pkg::SWC_RUN;
    assign osc_en_out = state_q != swc_pkg::SWC_STOPPED;
    assign core_reset_out = (state_q == swc_pkg::SWC_OSC_START)
                            | (state_q == swc_pkg::SWC_DELAY);
    assign full_reset_out = por_in | ext_reset_in;
    assign restart_addr_out = `SWC_RESTART_ADDR;
    assign div16_en_out = ctrl_q[`SWC_BIT_DIV16];
    assign bypass_div2_out = ctrl_q[`SWC_BIT_BYPASS2];
endmodule : swc_stop_control

/* File: logic/swc_defs.svh */
`ifndef SWC_DEFS_SVH
`define SWC_DEFS_SVH

// Register offsets on the plain port
`define SWC_ADDR_CTRL 4'h0
`define SWC_ADDR_EXTRA 4'h1
`define SWC_ADDR_IRQ_STAT 4'h2
`define SWC_ADDR_IRQ_MASK 4'h3
`define SWC_ADDR_STATUS 4'h4

// Control register fields
`define SWC_BIT_DIV16 0
`define SWC_BIT_BYPASS2 1
`define SWC_SRC_LO 2
`define SWC_SRC_HI 4
`define SWC_BIT_DELAY 5
`define SWC_BIT_LEVEL 6
`define SWC_BIT_WARM 7

// Control reset values: delay on, low level wake, divide by two
`define SWC_CTRL_RST 7'h20
`define SWC_EXTRA_RST 2'h0

// Interrupt status bits
`define SWC_IRQ_STOP 0
`define SWC_IRQ_WAKE 1
`define SWC_IRQ_READY 2
`define SWC_IRQ_W 3

// Status register codes for the sequencer state
`define SWC_STAT_RUN 3'h0
`define SWC_STAT_STOPPED 3'h1
`define SWC_STAT_OSC 3'h2
`define SWC_STAT_DELAY 3'h3
`define SWC_STAT_RELEASE 3'h4

// Restart vector and delay
`define SWC_RESTART_ADDR 16'h000C
`define SWC_DELAY_US 5000
`define SWC_CLK_KHZ 40000
`define SWC_FAST_HOLD 5
`define SWC_OSC_START 16

`endif

/* File: logic/swc_pkg.sv */
package swc_pkg;
    typedef enum logic [2:0] {
        SWC_RUN,
        SWC_STOPPED,
        SWC_OSC_START,
        SWC_DELAY,
        SWC_RELEASE
    } swc_state_t;
endpackage : swc_pkg

/* File: logic/swc_wake_detect.sv */
`include "swc_defs.svh"

module swc_wake_detect (
    input wire logic [2:0] src_sel_in,
    input wire logic [1:0] extra_sel_in,
    input wire logic level_high_in,
    input wire logic [3:0] port3_in,
    input wire logic [3:1] port3_analog_in,
    input wire logic [7:0] port2_pin_in,
    input wire logic [7:0] port2_drive_in,
    input wire logic [7:0] port2_out_en_in,
    output logic wake_out
);
    logic [7:0] port2_seen;
    logic raw;
    logic have;

    // Output-configured pins feed their own driven level back
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_p2
            assign port2_seen[i] = port2_out_en_in[i] ? port2_drive_in[i]
                                                      : port2_pin_in[i];
        end
    endgenerate

    always_comb begin
        raw = 1'b0;
        have = 1'b1;
        case (src_sel_in)
            3'h1: raw = port3_in[0];
            3'h2: begin
                raw = port3_in[1];
                have = ~port3_analog_in[1];
            end
            3'h3: begin
                raw = port3_in[2];
                have = ~port3_analog_in[2];
            end
            3'h4: begin
                raw = port3_in[3];
                have = ~port3_analog_in[3];
            end
            3'h5: raw = port2_seen[7];
            3'h6: raw = ~|port2_seen[3:0];
            3'h7: raw = ~|port2_seen;
            default: begin
                case (extra_sel_in)
                    2'h1: raw = &port2_seen[3:0];
                    2'h2: raw = &port2_seen;
                    default: have = 1'b0;
                endcase
            end
        endcase
    end

    // Level polarity chooses which level of the source wakes
    assign wake_out = have & (raw == level_high_in);
endmodule : swc_wake_detect

/* File: sim/swc_stop_control_chk.sv */
`include "swc_defs.svh"

module swc_stop_control_chk (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    input wire logic por_in,
    input wire logic ext_reset_in,
    input wire logic watchdog_timeout_in,
    input wire logic stop_exec_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic core_clk_en_out,
    input wire logic osc_en_out,
    input wire logic core_reset_out,
    input wire logic full_reset_out,
    input wire logic [15:0] restart_addr_out,
    input wire logic div16_en_out,
    input wire logic bypass_div2_out,
    input wire logic sys_tick_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    logic hard;
    logic ctrl_wr;
    assign hard = por_in | ext_reset_in | watchdog_timeout_in;
    assign ctrl_wr = reg_write_in && clk_en_in && !full_reset_out
        && reg_addr_in == `SWC_ADDR_CTRL;
    // Oscillator start-up spans sixteen cycles before any delay
    sequence osc_phase;
        core_reset_out [*8] ##1 core_reset_out [*8];
    endsequence
    sequence release_step;
        !core_clk_en_out ##1 core_clk_en_out;
    endsequence
    stop_entry_a: assert property (stop_exec_in && core_clk_en_out
        && clk_en_in && !hard |=> !core_clk_en_out && !osc_en_out)
        else $error("stop not entered");
    hard_wake_a: assert property (!osc_en_out && hard && clk_en_in
        |=> osc_en_out) else $error("hard reset did not wake");
    restart_vec_a: assert property (restart_addr_out == 16'h000C)
        else $error("restart address wrong");
    full_reset_a: assert property (full_reset_out ==
        (por_in | ext_reset_in)) else $error("full reset mismatch");
    osc_restart_a: assert property ($rose(osc_en_out)
        && !$past(full_reset_out) |-> core_reset_out)
        else $error("core not held after oscillator restart");
    osc_hold_a: assert property ($rose(core_reset_out) |-> osc_phase)
        else $error("start-up hold too short");
    release_run_a: assert property ($fell(core_reset_out)
        |-> release_step) else $error("release not one cycle");
    div16_write_a: assert property (ctrl_wr
        |=> div16_en_out == $past(reg_wdata_in[`SWC_BIT_DIV16]))
        else $error("divide by 16 not updated");
    bypass_write_a: assert property (ctrl_wr
        |=> bypass_div2_out == $past(reg_wdata_in[`SWC_BIT_BYPASS2]))
        else $error("divide by two not updated");
    tick_gate_a: assert property (sys_tick_out |-> core_clk_en_out)
        else $error("tick while core clock off");
    tick_full_a: assert property (core_clk_en_out && bypass_div2_out
        && !div16_en_out |-> sys_tick_out)
        else $error("tick missing with divider bypassed");
    tick_half_a: assert property (core_clk_en_out && !bypass_div2_out
        && !div16_en_out && $past(core_clk_en_out) && $past(clk_en_in)
        && $past(reset_n_in) && !$past(bypass_div2_out)
        && !$past(div16_en_out) |-> sys_tick_out != $past(sys_tick_out))
        else $error("tick not alternating at divide by two");
    read_idle_a: assert property (!reg_read_in |=> reg_rdata_out == 8'h00)
        else $error("read data outside read slot");
endmodule : swc_stop_control_chk

/* File: sim/stop_mode_recovery_control_test.sv */
`include "swc_defs.svh"

module stop_mode_recovery_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DLY = 40;
    localparam int OSC = 16;
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic por = 1'b0, ext = 1'b0, wdt = 1'b0, stp = 1'b0;
    logic wr_s = 1'b0, rd_s = 1'b0;
    logic [3:0] addr = 4'h0, p3 = 4'h0, n3;
    logic [7:0] wd = 8'h00, p2 = 8'h00, drv = 8'h00, oen = 8'h00;
    logic [7:0] n2, nd, no;
    logic [2:0] ana = 3'h0;
    logic [7:0] rdata;
    logic [15:0] raddr;
    logic core_clk, osc, core_rst, div16, byp, irq, tick, frst;
    logic cen = 1'b1;
    int fail_count = 0;
    int total_checks = 0;

    always #12.5 clk_sys_in = ~clk_sys_in;

    swc_stop_control #(.DELAY_CYCLES(DLY)) swc_stop_control_inst (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .clk_en_in(cen), .por_in(por), .ext_reset_in(ext),
        .watchdog_timeout_in(wdt), .stop_exec_in(stp),
        .reg_addr_in(addr), .reg_wdata_in(wd),
        .reg_write_in(wr_s), .reg_read_in(rd_s),
        .port3_in(p3), .port3_analog_in(ana), .port2_pin_in(p2),
        .port2_drive_in(drv), .port2_out_en_in(oen),
        .reg_rdata_out(rdata), .core_clk_en_out(core_clk),
        .osc_en_out(osc), .core_reset_out(core_rst),
        .full_reset_out(frst), .restart_addr_out(raddr),
        .div16_en_out(div16), .bypass_div2_out(byp),
        .sys_tick_out(tick), .irq_out(irq)
    );

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        wd <= d;
        wr_s <= 1'b1;
        @(posedge clk_sys_in);
        wr_s <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(logic [3:0] a, logic [7:0] e, string n);
        @(posedge clk_sys_in);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_sys_in);
        rd_s <= 1'b0;
        #1;
        chk(n, e, rdata);
    endtask : rd

    // Reference wake decision: level match of the selected source
    function automatic bit wk(logic [6:0] c, logic [1:0] x, logic [2:0] a);
        logic [7:0] e;
        logic v;
        e = (no & nd) | (~no & n2);
        case (c[4:2])
            3'd1: v = n3[0];
            3'd2: v = a[0] ? ~c[6] : n3[1];
            3'd3: v = a[1] ? ~c[6] : n3[2];
            3'd4: v = a[2] ? ~c[6] : n3[3];
            3'd5: v = e[7];
            3'd6: v = ~|e[3:0];
            3'd7: v = ~|e;
            default: v = x == 2'd1 ? &e[3:0] : x == 2'd2 ? &e : ~c[6];
        endcase
        return v == c[6];
    endfunction : wk

    task automatic ports(logic [6:0] c, logic [1:0] x, logic [2:0] a,
            bit want);
        repeat (4000) begin
            n3 = 4'($urandom);
            n2 = 8'($urandom);
            nd = 8'($urandom);
            no = 8'($urandom);
            if (wk(c, x, a) == want) break;
        end
        // Analog pin shows the wake level yet must stay ignored
        if (a[0]) n3[1] = c[6];
        @(posedge clk_sys_in);
        p3 <= n3;
        p2 <= n2;
        drv <= nd;
        oen <= no;
        ana <= a;
    endtask : ports

    task automatic stop;
        @(posedge clk_sys_in);
        stp <= 1'b1;
        @(posedge clk_sys_in);
        stp <= 1'b0;
        #1;
        chk("osc_en", 0, osc);
        chk("core_clk_en", 0, core_clk);
    endtask : stop

    task automatic wt(output int n);
        n = 0;
        repeat (200) begin
            @(posedge clk_sys_in);
            #1;
            if (core_rst) n++;
            if (core_clk) break;
        end
    endtask : wt

    initial begin
        int n;
        int ticks;
        int exp_t;
        logic [6:0] c;
        logic [1:0] x;
        void'($urandom(2689));
        repeat (5) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        rd(`SWC_ADDR_CTRL, 8'h00, "ctrl");
        rd(4'hF, 8'h00, "unmapped");
        chk("bypass", 0, byp);
        chk("div16", 0, div16);
        for (int k = 1; k < 10; k++) begin
            x = 2'(k > 7 ? k - 7 : 0);
            c = {1'($urandom), 1'(k == 3), 3'(k > 7 ? 0 : k), 2'($urandom)};
            wr(`SWC_ADDR_CTRL, {1'b0, c});
            wr(`SWC_ADDR_EXTRA, {6'h00, x});
            ports(c, x, 3'(k == 2), 1'b0);
            stop();
            repeat (8) @(posedge clk_sys_in);
            #1 chk("osc_en", 0, osc);
            rd(`SWC_ADDR_CTRL, 8'h80, "warm");
            rd(`SWC_ADDR_STATUS, 8'h01, "status");
            ports(c, x, 3'h0, 1'b1);
            wt(n);
            chk("reset_len", 16'(OSC + (k == 3 ? DLY : 0)), 16'(n));
            chk("restart", 16'h000C, raddr);
            chk("div16", c[0], div16);
            chk("bypass", c[1], byp);
            // Any 32 consecutive running cycles hold a whole tick pattern
            ticks = 0;
            repeat (32) begin
                @(posedge clk_sys_in);
                #1 if (tick === 1'b1) ticks++;
            end
            exp_t = 32 / ((c[1] ? 1 : 2) * (c[0] ? 16 : 1));
            chk("ticks", 16'(exp_t), 16'(ticks));
        end
        rd(`SWC_ADDR_IRQ_STAT, 8'h07, "irq_stat");
        wr(`SWC_ADDR_IRQ_MASK, 8'h02);
        chk("irq", 1, irq);
        // Enable low freezes the mask, so this write must not land
        @(posedge clk_sys_in);
        cen <= 1'b0;
        wr(`SWC_ADDR_IRQ_MASK, 8'h00);
        chk("irq_frozen", 1, irq);
        @(posedge clk_sys_in);
        cen <= 1'b1;
        wr(`SWC_ADDR_IRQ_STAT, 8'h02);
        chk("irq", 0, irq);
        rd(`SWC_ADDR_IRQ_STAT, 8'h05, "irq_stat");
        for (int h = 0; h < 3; h++) begin
            wr(`SWC_ADDR_CTRL, 8'h23);
            wr(`SWC_ADDR_EXTRA, 8'h00);
            stop();
            repeat (4) @(posedge clk_sys_in);
            #1 chk("osc_en", 0, osc);
            @(posedge clk_sys_in);
            por <= h == 0;
            ext <= h == 1;
            wdt <= h == 2;
            #1 chk("full_reset", 16'(h < 2), frst);
            @(posedge clk_sys_in);
            por <= 1'b0;
            ext <= 1'b0;
            wdt <= 1'b0;
            wt(n);
            chk("core_clk_en", 1, core_clk);
            rd(`SWC_ADDR_CTRL, h == 0 ? 8'h00 : 8'h80, "warm");
            chk("div16", h == 2, div16);
        end
        test_done();
    end

    initial begin
        #(25ns * 20000);
        fail_count++;
        test_done();
    end
endmodule : stop_mode_recovery_control_test

bind swc_stop_control swc_stop_control_chk swc_stop_control_chk_inst (.*);
